/* core/sbp_port.sv */
`timescale 1ns/1ns
module sbp_port (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Timer and DMA controls from neighbouring blocks
    input  wire logic [3:0]  timer_output_select_0,
    input  wire logic [3:0]  timer_output_select_1,
    input  wire logic        timer_compare_out_0,
    input  wire logic        timer_compare_out_1,
    input  wire logic        dma_ack_out_0,
    input  wire logic        dma_ack_out_1,
    input  wire logic        transfer_end_out_1,
    // Port pins
    input  wire logic [5:0]  pin_i,
    output logic [5:0]       pin_o,
    output logic [5:0]       pin_oe,
    // Inputs toward interrupt controller and timer
    output logic             ext_irq_11,
    output logic             ext_irq_12,
    output logic             ext_irq_13,
    output logic             timer_ext_clock_in_1
);

    typedef struct packed {
        logic [5:0]  dir;
        logic [5:0]  latch;
        logic [9:0]  alt;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sbp_state_t;

    sbp_state_t st_r;
    sbp_state_t st_nxt;

    logic [5:0] level_view;
    logic       wr_fire;
    logic       rd_fire;

    // Readback mixes latch for outputs and pins for inputs
    assign level_view = (st_r.dir & st_r.latch) | (~st_r.dir & pin_i);

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wr_fire = (st_r.aw_got || (s_axi_awvalid && s_axi_awready))
                  && (st_r.w_got || (s_axi_wvalid && s_axi_wready));

    always_comb begin
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        waddr  = 8'h00;
        wdata  = 32'h0000_0000;
        wstrb  = 4'h0;
        st_nxt = st_r;

        // Write channel: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        waddr = st_r.aw_got ? st_r.aw_addr : s_axi_awaddr;
        wdata = st_r.w_got ? st_r.w_data : s_axi_wdata;
        wstrb = st_r.w_got ? st_r.w_strb : s_axi_wstrb;
        if (wr_fire) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = sbp_pkg::RESP_OKAY;
            // Lane 0 carries the port bits and lane 1 alt bits 9:8; upper bits are dropped
            unique case ({waddr[7:2], 2'b00})
                sbp_pkg::ADDR_PIN_DIRECTION: begin
                    if (wstrb[0]) begin
                        st_nxt.dir = wdata[5:0];
                    end
                end
                sbp_pkg::ADDR_OUTPUT_LATCH: begin
                    if (wstrb[0]) begin
                        st_nxt.latch = wdata[5:0];
                    end
                end
                sbp_pkg::ADDR_PIN_LEVEL: begin
                    st_nxt.bresp = sbp_pkg::RESP_OKAY;
                end
                sbp_pkg::ADDR_ALT_CTRL: begin
                    if (wstrb[0]) begin
                        st_nxt.alt[7:0] = wdata[7:0];
                    end
                    if (wstrb[1]) begin
                        st_nxt.alt[9:8] = wdata[9:8];
                    end
                end
                default: begin
                    st_nxt.bresp = sbp_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel
        if (rd_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = sbp_pkg::RESP_OKAY;
            st_nxt.rdata  = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                sbp_pkg::ADDR_PIN_DIRECTION: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
                sbp_pkg::ADDR_OUTPUT_LATCH: begin
                    st_nxt.rdata = {26'h0, st_r.latch};
                end
                sbp_pkg::ADDR_PIN_LEVEL: begin
                    st_nxt.rdata = {26'h0, level_view};
                end
                sbp_pkg::ADDR_ALT_CTRL: begin
                    st_nxt.rdata = {22'h0, st_r.alt};
                end
                default: begin
                    st_nxt.rresp = sbp_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r       <= '0;
            st_r.dir   <= sbp_pkg::DIR_RST;
            st_r.latch <= sbp_pkg::LATCH_RST;
            st_r.alt   <= sbp_pkg::ALT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    sbp_pin_mux u_mux (
        .pin_direction               (st_r.dir),
        .output_latch                (st_r.latch),
        .dma_pin_select              (st_r.alt[sbp_pkg::ALT_DMA_PIN_SEL]),
        .single_address_enable_ch0   (st_r.alt[sbp_pkg::ALT_SAE_CH0]),
        .single_address_enable_ch1   (st_r.alt[sbp_pkg::ALT_SAE_CH1]),
        .transfer_end_out_enable_ch1 (st_r.alt[sbp_pkg::ALT_TEE_CH1]),
        .timer_output_select_0       (timer_output_select_0),
        .timer_output_select_1       (timer_output_select_1),
        .timer_compare_out_0         (timer_compare_out_0),
        .timer_compare_out_1         (timer_compare_out_1),
        .dma_ack_out_0               (dma_ack_out_0),
        .dma_ack_out_1               (dma_ack_out_1),
        .transfer_end_out_1          (transfer_end_out_1),
        .pin_o                       (pin_o),
        .pin_oe                      (pin_oe)
    );

    // Interrupt taps follow the pin whatever drives it; 1 parks the line high
    logic [2:0] irq_tap;
    for (genvar g = 0; g < 3; g++) begin : g_irq_tap
        assign irq_tap[g] = st_r.alt[sbp_pkg::ALT_IRQ_SEL_11 + g] ? 1'b1
                          : pin_i[sbp_pkg::PIN_TRANSFER_END_OUT_1 + g];
    end
    assign ext_irq_11 = irq_tap[0];
    assign ext_irq_12 = irq_tap[1];
    assign ext_irq_13 = irq_tap[2];
    assign timer_ext_clock_in_1 = pin_i[3];

endmodule

/* core/sbp_pkg.sv */
package sbp_pkg;

    // Register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT_LATCH  = 8'h04;
    localparam logic [7:0] ADDR_PIN_LEVEL     = 8'h08;
    localparam logic [7:0] ADDR_ALT_CTRL      = 8'h0C;

    // Port geometry
    localparam int         PORT_W  = 6;
    localparam int         ADDR_W  = 8;

    // Reset values
    localparam logic [5:0] DIR_RST   = 6'h00;
    localparam logic [5:0] LATCH_RST = 6'h00;
    localparam logic [9:0] ALT_RST   = 10'h000;

    // Alternate-control register field positions
    localparam int ALT_DMA_PIN_SEL = 0;
    localparam int ALT_SAE_CH0     = 1;
    localparam int ALT_SAE_CH1     = 2;
    localparam int ALT_TEE_CH1     = 3;
    localparam int ALT_IRQ_SEL_11  = 4;
    localparam int ALT_IRQ_SEL_12  = 5;
    localparam int ALT_IRQ_SEL_13  = 6;
    localparam int ALT_W           = 10;

    // Pin indices
    localparam int PIN_TRANSFER_END_OUT_1 = 3;
    localparam int PIN_ACK0  = 4;
    localparam int PIN_ACK1  = 5;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* core/sbp_pin_mux.sv */
`timescale 1ns/1ns
module sbp_pin_mux (
    // Configuration
    input  wire logic [5:0] pin_direction,
    input  wire logic [5:0] output_latch,
    input  wire logic       dma_pin_select,
    input  wire logic       single_address_enable_ch0,
    input  wire logic       single_address_enable_ch1,
    input  wire logic       transfer_end_out_enable_ch1,
    input  wire logic [3:0] timer_output_select_0,
    input  wire logic [3:0] timer_output_select_1,
    // Alternate sources
    input  wire logic       timer_compare_out_0,
    input  wire logic       timer_compare_out_1,
    input  wire logic       dma_ack_out_0,
    input  wire logic       dma_ack_out_1,
    input  wire logic       transfer_end_out_1,
    // Pin drive
    output logic [5:0]      pin_o,
    output logic [5:0]      pin_oe
);

    logic ack1_sel;
    logic ack0_sel;
    logic tend_sel;
    logic timer_compare_out_1_sel;
    logic timer_compare_out_0_sel;

    assign ack1_sel = single_address_enable_ch1 && !dma_pin_select;
    assign ack0_sel = single_address_enable_ch0 && !dma_pin_select;
    assign tend_sel = transfer_end_out_enable_ch1 && !dma_pin_select;
    assign timer_compare_out_1_sel = !ack1_sel && (timer_output_select_1 != 4'h0);
    assign timer_compare_out_0_sel = !ack0_sel && (timer_output_select_0 != 4'h0);

    always_comb begin
        // Plain GPIO by default; zero reset values leave drivers off except timer outputs on pins 4 and 5 when a timer output select is nonzero
        pin_o  = output_latch;
        pin_oe = pin_direction;
        if (ack1_sel) begin
            pin_o[sbp_pkg::PIN_ACK1]  = dma_ack_out_1;
            pin_oe[sbp_pkg::PIN_ACK1] = 1'b1;
        end else if (timer_compare_out_1_sel) begin
            pin_o[sbp_pkg::PIN_ACK1]  = timer_compare_out_1;
            pin_oe[sbp_pkg::PIN_ACK1] = 1'b1;
        end
        if (ack0_sel) begin
            pin_o[sbp_pkg::PIN_ACK0]  = dma_ack_out_0;
            pin_oe[sbp_pkg::PIN_ACK0] = 1'b1;
        end else if (timer_compare_out_0_sel) begin
            pin_o[sbp_pkg::PIN_ACK0]  = timer_compare_out_0;
            pin_oe[sbp_pkg::PIN_ACK0] = 1'b1;
        end
        if (tend_sel) begin
            pin_o[sbp_pkg::PIN_TRANSFER_END_OUT_1]  = transfer_end_out_1;
            pin_oe[sbp_pkg::PIN_TRANSFER_END_OUT_1] = 1'b1;
        end
    end

endmodule

/* bench/sbp_board.sv */
`timescale 1ns/1ns
module sbp_board (
    // Port side
    input  wire logic [5:0] pin_o,
    input  wire logic [5:0] pin_oe,
    // Board side
    input  wire logic [5:0] ext_lvl,
    output logic [5:0]      pin_i
);
    // A driven pin shows the port's value, an undriven one the board's level
    always_comb pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule

/* bench/sbp_port_sva.sv */
`timescale 1ns/1ns
module sbp_port_sva (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pins and taps
    input wire logic [5:0]  pin_i,
    input wire logic [5:0]  pin_oe,
    input wire logic        ext_irq_13,
    input wire logic        timer_ext_clock_in_1
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_rd_reserved: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0) else $error("upper bits set");
    a_ext_irq_13_tap: assert property (ext_irq_13 || ext_irq_13 == pin_i[5])
        else $error("irq tap wrong");
    a_tclk_tap: assert property (timer_ext_clock_in_1 == pin_i[3])
        else $error("timer clock tap wrong");
    a_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> pin_oe[3:0] == 4'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("not quiet after reset");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pin5: cover property (pin_oe[5]);
endmodule

/* bench/test_six_bit_port_with_alt_functions.sv */
`timescale 1ns/1ns
module test_six_bit_port_with_alt_functions;
    typedef struct packed {
        logic [5:0] dir, lat;
        logic [7:0] alt;
        logic [3:0] t0, t1;
        logic [4:0] src;
        logic [5:0] ext, oe, o, lvl;
    } sbp_row_t;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, timer_compare_out_0, timer_compare_out_1, dma_ack_out_0;
    logic        dma_ack_out_1, transfer_end_out_1, ext_irq_11, ext_irq_12, ext_irq_13;
    logic        timer_ext_clock_in_1;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb, timer_output_select_0, timer_output_select_1;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [5:0]  pin_i, pin_o, pin_oe, ext_lvl;
    int          n_errors, cmp_count, cyc;
    sbp_row_t    r;
    sbp_row_t    rows [7] = '{
        '{6'h3F, 6'h2A, 8'h00, 4'h0, 4'h0, 5'h00, 6'h15, 6'h3F, 6'h2A, 6'h2A},
        '{6'h00, 6'h3F, 8'h00, 4'h0, 4'h0, 5'h00, 6'h15, 6'h00, 6'h00, 6'h15},
        '{6'h0F, 6'h05, 8'h00, 4'h0, 4'h0, 5'h00, 6'h30, 6'h0F, 6'h05, 6'h35},
        '{6'h00, 6'h00, 8'h0E, 4'h3, 4'h2, 5'h17, 6'h00, 6'h38, 6'h18, 6'h18},
        '{6'h00, 6'h00, 8'h0F, 4'h1, 4'h0, 5'h1D, 6'h2A, 6'h10, 6'h10, 6'h3A},
        '{6'h30, 6'h10, 8'h00, 4'h0, 4'h8, 5'h00, 6'h0F, 6'h30, 6'h10, 6'h1F},
        '{6'h00, 6'h00, 8'h70, 4'h0, 4'h0, 5'h00, 6'h00, 6'h00, 6'h00, 6'h00}};

    sbp_port DUT (.*);
    sbp_board BOARD (.*);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic finish_test;
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            finish_test;
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t pins got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] x);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            // Late ready makes the response stand for a cycle
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        x = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] x);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        v = s_axi_rdata;
        x = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_lvl} = '0;
        {timer_output_select_0, timer_output_select_1} = '0;
        {transfer_end_out_1, dma_ack_out_1, dma_ack_out_0} = '0;
        {timer_compare_out_1, timer_compare_out_0} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            wr(8'h00, {26'h0, r.dir}, rs);
            wr(8'h04, {26'h0, r.lat}, rs);
            wr(8'h0C, {24'h0, r.alt}, rs);
            timer_output_select_0 <= r.t0;
            timer_output_select_1 <= r.t1;
            {transfer_end_out_1, dma_ack_out_1, dma_ack_out_0} <= r.src[4:2];
            {timer_compare_out_1, timer_compare_out_0} <= r.src[1:0];
            ext_lvl <= r.ext;
            @(negedge aclk);
            chk_pin(pin_oe, r.oe);
            chk_pin(pin_o & pin_oe, r.o);
            chk_pin({2'h0, timer_ext_clock_in_1, ext_irq_13, ext_irq_12, ext_irq_11},
                {2'h0, pin_i[3], r.alt[6:4] | pin_i[5:3]});
            rd(8'h08, d, rs);
            chk_reg(d, {26'h0, r.lvl});
        end
        // Upper latch bits must not stick
        wr(8'h04, 32'hFFFF_FFFF, rs);
        rd(8'h04, d, rs);
        chk_reg(d, 32'h0000_003F);
        wr(8'h00, 32'h0000_003F, rs);
        rd(8'h00, d, rs);
        chk_reg(d, 32'h0000_0000);
        wr(8'h08, 32'h0000_0000, rs);
        chk_reg({30'h0, rs}, {30'h0, sbp_pkg::RESP_OKAY});
        rd(8'h08, d, rs);
        chk_reg(d, 32'h0000_003F);
        wr(8'h10, 32'h0000_0001, rs);
        chk_reg({30'h0, rs}, {30'h0, sbp_pkg::RESP_SLVERR});
        rd(8'h10, d, rs);
        chk_reg({30'h0, rs}, {30'h0, sbp_pkg::RESP_SLVERR});
        // Second reset while every pin is an output
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk_pin(pin_oe, 6'h00);
        rd(8'h04, d, rs);
        chk_reg(d, 32'h0000_0000);
        rd(8'h0C, d, rs);
        chk_reg(d, 32'h0000_0000);
        finish_test;
    end
endmodule

bind sbp_port sbp_port_sva CHK (.*);
